/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0;  // 250 MHz clock
    logic        rst_i = 1'b1;  // Sync reset
    logic        cyc_i = 1'b0;  // Bus cycle
    logic        stb_i = 1'b0;  // Bus strobe
    logic        we_i  = 1'b0;  // Write enable
    logic [7:0]  adr_i = 8'h00; // Byte address
    logic [3:0]  sel_i = 4'h0;  // Byte enables
    logic [31:0] dat_i = 32'h0; // Write data
    logic [31:0] dat_o;         // Read data
    logic        ack_o;         // Bus acknowledge
    logic        sleeping_o;    // Asleep level
    int          failures  = 0; // Mismatch count
    int          tests_run = 0; // Comparison count
    int          cycles    = 0; // Hang guard
    logic [31:0] rd;            // Scratch read value
    logic [31:0] st;            // Scratch status value
    logic [31:0] pc;            // Scratch program counter
    ////////////////////////////////////////////////////////////////////////////////
    exec_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sleeping_o(sleeping_o));
    // Clock generator
    always #2 clk_i = ~clk_i;
    // Hang guard, well above the longest sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Load an instruction, start it, poll busy with a bound
    task automatic run(input logic [31:0] ins, input logic ext);
        int n;
        wb(1'b1, exec_pkg::off_instr, ins, rd);
        wb(1'b1, exec_pkg::off_control, {30'h0, ext, 1'b1}, rd);
        n = 0;
        do begin
            wb(1'b0, exec_pkg::off_control, 32'h0, rd);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        chk({31'h0, rd[0]}, 32'h0, "busy stuck");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Computed call: push, reload, nothing else touched
    task automatic t_call();
        wb(1'b1, exec_pkg::off_accum, 32'h06, rd);
        wb(1'b1, exec_pkg::off_latch, 32'h0010, rd);
        wb(1'b1, exec_pkg::off_bank, 32'h5, rd);
        wb(1'b0, exec_pkg::off_status, 32'h0, st);
        chk(st, 32'h0c, "reset flags");
        run({16'h0, exec_pkg::op_computed_call}, 1'b0);
        wb(1'b0, exec_pkg::off_pc, 32'h0, rd);
        chk(rd, 32'h1006, "call target");
        wb(1'b0, exec_pkg::off_stack_head, 32'h0, rd);
        chk(rd, 32'h2, "return address");
        wb(1'b0, exec_pkg::off_accum, 32'h0, rd);
        chk(rd, 32'h06, "accum kept");
        wb(1'b0, exec_pkg::off_status, 32'h0, rd);
        chk(rd, st, "flags kept");
        wb(1'b0, exec_pkg::off_bank, 32'h0, rd);
        chk(rd, 32'h5, "bank kept");
        $display("test call done");
    endtask
    // Register clear over all addressing modes
    task automatic t_clear();
        logic [15:0] ins [5];
        logic        ext [5];
        logic [11:0] adr [5];
        ins = '{16'h6b12, 16'h6a40, 16'h6a90, 16'h6a20, 16'h6a60};
        ext = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        adr = '{12'h512, 12'h040, 12'hf90, 12'h120, 12'h060};
        wb(1'b1, exec_pkg::off_ptr0 + 8'h08, 32'h0100, rd);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, exec_pkg::off_target_dat, 32'h5a, rd);
            run({16'h0, ins[i]}, ext[i]);
            wb(1'b0, exec_pkg::off_target, 32'h0, rd);
            chk({20'h0, rd[11:0]}, {20'h0, adr[i]}, "clear address");
            wb(1'b0, exec_pkg::off_target_dat, 32'h0, rd);
            chk(rd, 32'h0, "clear data");
            wb(1'b0, exec_pkg::off_status, 32'h0, rd);
            chk({31'h0, rd[1]}, 32'h1, "zero flag");
        end
        $display("test clear done");
    endtask
    // Pointer subtract, boundary literal, flags untouched
    task automatic t_sub();
        wb(1'b1, exec_pkg::off_ptr0 + 8'h08, 32'h03ff, rd);
        wb(1'b1, exec_pkg::off_ptr0, 32'h0100, rd);
        wb(1'b0, exec_pkg::off_status, 32'h0, st);
        run(32'h0000_e9a3, 1'b0);
        wb(1'b0, exec_pkg::off_ptr0 + 8'h08, 32'h0, rd);
        chk(rd, 32'h03dc, "pointer 2");
        run(32'h0000_e93f, 1'b0);
        wb(1'b0, exec_pkg::off_ptr0, 32'h0, rd);
        chk(rd, 32'h00c1, "pointer 0");
        wb(1'b0, exec_pkg::off_status, 32'h0, rd);
        chk(rd, st, "no flags");
        $display("test sub done");
    endtask
    // Two-word move confined to the low 4k
    task automatic t_move();
        wb(1'b0, exec_pkg::off_pc, 32'h0, pc);
        run(32'hffa5_ce12, 1'b0);
        wb(1'b0, exec_pkg::off_target, 32'h0, rd);
        chk(rd, 32'h0fa5, "move dest");
        wb(1'b0, exec_pkg::off_pc, 32'h0, rd);
        chk(rd, pc + 32'h4, "move pc");
        $display("test move done");
    endtask
    // Sleep entry, then watchdog wake
    task automatic t_sleep();
        int n;
        wb(1'b0, exec_pkg::off_pc, 32'h0, pc);
        run({16'h0, exec_pkg::op_sleep}, 1'b0);
        wb(1'b0, exec_pkg::off_status, 32'h0, rd);
        chk(rd & 32'h1c, 32'h18, "sleep flags");
        chk({31'h0, sleeping_o}, 32'h1, "asleep");
        repeat (2000) @(posedge clk_i);
        wb(1'b1, exec_pkg::off_control, 32'h4, rd);
        wb(1'b0, exec_pkg::off_status, 32'h0, rd);
        chk(rd & 32'h1c, 32'h08, "soft wake keeps expiry");
        wb(1'b0, exec_pkg::off_watchdog, 32'h0, st);
        chk({31'h0, st > 32'h400}, 32'h1, "watchdog ran");
        run({16'h0, exec_pkg::op_sleep}, 1'b0);
        wb(1'b0, exec_pkg::off_watchdog, 32'h0, rd);
        chk({31'h0, rd < 32'h40}, 32'h1, "watchdog cleared");
        wb(1'b0, exec_pkg::off_pc, 32'h0, rd);
        chk(rd, pc, "sleep pc");
        n = 0;
        while (sleeping_o !== 1'b0 && n < 6000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, sleeping_o}, 32'h0, "watchdog wake");
        wb(1'b0, exec_pkg::off_status, 32'h0, rd);
        chk({31'h0, rd[3]}, 32'h0, "expiry cleared");
        $display("test sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Closing report, the only exit
    task automatic results();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_call();
        t_clear();
        t_sub();
        t_move();
        t_sleep();
        results();
    end
endmodule // tb
`default_nettype wire

/* File: rtl/exec_core.sv */
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module exec_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             sleeping_o
);
    ////////////////////////////////////////////////////////////////////
    // Architectural state
    logic [20:0] pc_reg;           // Program counter
    logic [7:0]  accumulator_reg;  // Working register
    logic [7:0]  pc_latch_high;    // Latched high byte
    logic [7:0]  pc_latch_upper;   // Latched upper byte
    logic [20:0] return_stack_head;
    logic [5:0]  bank_selector;    // Bank select
    logic [13:0] ptr_reg [3];      // Indirect pointers 0..2
    logic        zero_flag;
    logic        powerdown_flag;
    logic        watchdog_expiry_flag;
    logic [7:0]  watchdog_counter;
    logic [3:0]  postscaler_reg;
    logic        asleep_reg;
    logic [13:0] wr_addr_reg;      // Last data write address
    logic [7:0]  wr_data_reg;      // Last data write value
    // Control
    logic [31:0] instr_reg;        // Low: first word, high: second word
    logic        ext_en_reg;       // Extended set enable
    logic        busy_reg;
    logic        nop_cycle_reg;    // Pending no-operation cycle
    exec_pkg::phase_t phase_reg;
    logic        ack_reg;

    ////////////////////////////////////////////////////////////////////
    // Decode, done in the first quarter phase
    wire logic [15:0] w0 = instr_reg[15:0];
    wire logic is_call  = (w0 == exec_pkg::op_computed_call);
    wire logic is_sleep = (w0 == exec_pkg::op_sleep);
    wire logic is_clr   = (w0[15:9] == exec_pkg::op_clear_file);
    wire logic is_subp  = (w0[15:8] == exec_pkg::op_sub_pointer);
    wire logic is_move  = (w0[15:12] == exec_pkg::op_move_two);
    wire logic acc_bit  = w0[8];
    wire logic [7:0] fld = w0[7:0];

    // Data address for clear: access bank, banked RAM, or indexed
    logic [13:0] clr_addr;
    always_comb begin
        if (acc_bit) begin
            clr_addr = {bank_selector, fld};
        end else if (ext_en_reg && (fld <= exec_pkg::idx_limit)) begin
            clr_addr = ptr_reg[2] + {6'h00, fld};
        end else if (fld[7]) begin
            clr_addr = {2'b00, exec_pkg::access_sfr_bank, fld};
        end else begin
            clr_addr = {6'h00, fld};
        end
    end

    // Two-word move destination: top two bank bits forced to zero
    wire logic [13:0] move_dst = {2'b00, instr_reg[27:16]};

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave; one wait state, ack drops the cycle after
    wire logic req  = cyc_i && stb_i && !ack_reg;
    wire logic wr   = req && we_i;
    wire logic go   = wr && (adr_i == exec_pkg::off_control) && sel_i[0] && dat_i[0] && !busy_reg;
    wire logic wake = wr && (adr_i == exec_pkg::off_control) && sel_i[0] && dat_i[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end
    assign ack_o = ack_reg;
    assign sleeping_o = asleep_reg;

    // Read mux registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            unique case (adr_i)
                exec_pkg::off_control:    dat_o <= {30'h0, ext_en_reg, busy_reg};
                exec_pkg::off_instr:      dat_o <= instr_reg;
                exec_pkg::off_accum:      dat_o <= {24'h0, accumulator_reg};
                exec_pkg::off_status:     dat_o <= {27'h0, asleep_reg, watchdog_expiry_flag,
                                                    powerdown_flag, zero_flag, busy_reg};
                exec_pkg::off_pc:         dat_o <= {11'h0, pc_reg};
                exec_pkg::off_latch:      dat_o <= {16'h0, pc_latch_upper, pc_latch_high};
                exec_pkg::off_stack_head: dat_o <= {11'h0, return_stack_head};
                exec_pkg::off_bank:       dat_o <= {26'h0, bank_selector};
                exec_pkg::off_ptr0:         dat_o <= {18'h0, ptr_reg[0]};
                exec_pkg::off_ptr0 + 8'h04: dat_o <= {18'h0, ptr_reg[1]};
                exec_pkg::off_ptr0 + 8'h08: dat_o <= {18'h0, ptr_reg[2]};
                exec_pkg::off_target:     dat_o <= {18'h0, wr_addr_reg};
                exec_pkg::off_target_dat: dat_o <= {24'h0, wr_data_reg};
                exec_pkg::off_watchdog:   dat_o <= {20'h0, postscaler_reg, watchdog_counter};
                default:                  dat_o <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: quarter phases, busy, extra no-operation cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg      <= 1'b0;
            phase_reg     <= exec_pkg::ph_q1;
            nop_cycle_reg <= 1'b0;
        end else if (go) begin
            busy_reg  <= 1'b1;
            phase_reg <= exec_pkg::ph_q1;
        end else if (busy_reg) begin
            phase_reg <= exec_pkg::phase_t'(phase_reg + 2'd1);
            if (phase_reg == exec_pkg::ph_q4) begin
                if (!nop_cycle_reg && (is_call || is_move)) begin
                    nop_cycle_reg <= 1'b1;
                end else begin
                    nop_cycle_reg <= 1'b0;
                    busy_reg      <= 1'b0;
                end
            end
        end
    end

    // Execute strobes in the first cycle only
    wire logic exec_cyc = busy_reg && !nop_cycle_reg;
    wire logic at_q3 = exec_cyc && (phase_reg == exec_pkg::ph_q3);
    wire logic at_q4 = exec_cyc && (phase_reg == exec_pkg::ph_q4);
    logic [7:0] read_val;  // Value read in Q2
    logic [7:0] proc_val;  // Value processed in Q3

    // Read then process, one phase each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_val <= 8'h00;
            proc_val <= 8'h00;
        end else if (exec_cyc && phase_reg == exec_pkg::ph_q2) begin
            read_val <= is_call ? accumulator_reg : 8'h00;
        end else if (at_q3) begin
            proc_val <= is_clr ? 8'h00 : read_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program counter and return stack; call touches no flags or bank
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg            <= exec_pkg::pc_reset;
            return_stack_head <= exec_pkg::pc_reset;
        end else if (at_q3 && is_call) begin
            return_stack_head <= pc_reg + 21'd2;
        end else if (at_q4 && is_call) begin
            pc_reg <= {pc_latch_upper[4:0], pc_latch_high, read_val};
        end else if (at_q4 && !is_sleep) begin
            pc_reg <= pc_reg + (is_move ? 21'd4 : 21'd2);
        end
    end

    // Register writes from software (accumulator, latches, bank, instr)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accumulator_reg <= 8'h00;
            pc_latch_high   <= 8'h00;
            pc_latch_upper  <= 8'h00;
            bank_selector   <= 6'h00;
            instr_reg       <= 32'h0000_0000;
            ext_en_reg      <= 1'b0;
        end else if (wr && !busy_reg) begin
            unique case (adr_i)
                exec_pkg::off_control:    ext_en_reg <= sel_i[0] ? dat_i[1] : ext_en_reg;
                exec_pkg::off_instr:      instr_reg <= dat_i;
                exec_pkg::off_accum:      accumulator_reg <= dat_i[7:0];
                exec_pkg::off_latch: begin
                    pc_latch_high  <= dat_i[7:0];
                    pc_latch_upper <= dat_i[15:8];
                end
                exec_pkg::off_bank:       bank_selector <= dat_i[5:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointers: subtract unsigned literal, flags untouched
    for (genvar i = 0; i < 3; i++) begin : g_ptr
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ptr_reg[i] <= 14'h0000;
            end else if (at_q4 && is_subp && (w0[7:6] == 2'(i))) begin
                ptr_reg[i] <= ptr_reg[i] - {8'h00, w0[5:0]};
            end else if (wr && !busy_reg && adr_i == 8'(exec_pkg::off_ptr0 + 4 * i)) begin
                ptr_reg[i] <= dat_i[13:0];
            end
        end
    end

    // Destination write, done in Q4 of the execute cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_addr_reg <= 14'h0000;
            wr_data_reg <= 8'h00;
            zero_flag   <= 1'b0;
        end else if (at_q4 && is_clr) begin
            wr_addr_reg <= clr_addr;
            wr_data_reg <= proc_val;
            zero_flag   <= 1'b1;
        end else if (at_q4 && is_move) begin
            wr_addr_reg <= move_dst;
            wr_data_reg <= proc_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sleep and watchdog flags
    // Counter at all ones: the next sleeping clock is the timeout
    wire logic wd_timeout = &{postscaler_reg, watchdog_counter};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powerdown_flag       <= 1'b1;
            watchdog_expiry_flag <= 1'b1;
            watchdog_counter     <= exec_pkg::watchdog_reset;
            postscaler_reg       <= 4'h0;
            asleep_reg           <= 1'b0;
        end else if (at_q4 && is_sleep) begin
            powerdown_flag       <= 1'b0;
            watchdog_expiry_flag <= 1'b1;
            watchdog_counter     <= exec_pkg::watchdog_reset;
            postscaler_reg       <= 4'h0;
            asleep_reg           <= 1'b1;  // Oscillator stopped
        end else if (asleep_reg) begin
            // Watchdog keeps counting while asleep; its wrap is the timeout
            {postscaler_reg, watchdog_counter} <= {postscaler_reg, watchdog_counter} + 12'd1;
            if (wd_timeout) begin
                // Timeout wake is the only wake that clears expiry
                asleep_reg           <= 1'b0;
                watchdog_expiry_flag <= 1'b0;
            end else if (wake) begin
                // Software wake keeps expiry set, so firmware can tell the two apart
                asleep_reg           <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    // Instruction start: go taken, then busy with the decoded kind
    sequence s_call_start;
        go ##1 (busy_reg && is_call);
    endsequence
    sequence s_move_start;
        go ##1 (busy_reg && is_move);
    endsequence
    sequence s_single_start;
        go ##1 (busy_reg && (is_clr || is_subp));
    endsequence
    // Two instruction cycles: eight quarter phases, then idle
    sequence s_two_cycles;
        busy_reg [*8] ##1 !busy_reg;
    endsequence
    // One instruction cycle: four quarter phases, then idle
    sequence s_one_cycle;
        busy_reg [*4] ##1 !busy_reg;
    endsequence
    a_call_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
        s_call_start |-> s_two_cycles)
        else $error("computed call not two cycles");
    a_call_push: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q3 && is_call) |=> return_stack_head == $past(pc_reg) + 21'd2)
        else $error("return address wrong");
    a_call_target: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_call) |=> pc_reg[7:0] == accumulator_reg && pc_reg[15:8] == pc_latch_high
            && pc_reg[20:16] == pc_latch_upper[4:0])
        else $error("call target wrong");
    a_call_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_reg && is_call)
        |=> $stable(bank_selector) && $stable(zero_flag) && $stable(accumulator_reg))
        else $error("call changed state");
    a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_clr) |=> zero_flag && wr_data_reg == 8'h00)
        else $error("clear failed");
    a_sleep_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_sleep) |=> !powerdown_flag && watchdog_expiry_flag && asleep_reg)
        else $error("sleep flags wrong");
    a_sub_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_subp) |=> $stable(zero_flag))
        else $error("pointer subtract touched flags");
    a_move_bank: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_move) |=> wr_addr_reg[13:12] == 2'b00)
        else $error("move bank not limited");
    a_wake_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep_reg && &{postscaler_reg, watchdog_counter} && !(at_q4 && is_sleep))
        |=> !watchdog_expiry_flag)
        else $error("expiry flag not cleared");
    // Extra no-operation cycle after the two-word move
    a_move_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
        s_move_start |-> s_two_cycles)
        else $error("move not two cycles");
    // Clear and pointer subtract finish in one instruction cycle
    a_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_single_start |-> s_one_cycle)
        else $error("single cycle instruction overran");
    // Nothing architectural moves during the no-operation cycle
    a_nop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_reg && nop_cycle_reg)
        |=> $stable(pc_reg) && $stable(return_stack_head) && $stable(wr_addr_reg))
        else $error("no-operation cycle changed state");
    // Accumulator is read in the second quarter phase
    a_read_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        (exec_cyc && phase_reg == exec_pkg::ph_q2 && is_call)
        |=> read_val == $past(accumulator_reg))
        else $error("accumulator not read in second phase");
    // Banked clear address comes from the bank selector
    a_clear_bank: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_clr && acc_bit) |=> wr_addr_reg == {$past(bank_selector), $past(fld)})
        else $error("banked clear address wrong");
    // Indexed clear address is pointer 2 plus the field
    a_clear_index: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_clr && !acc_bit && ext_en_reg && fld <= exec_pkg::idx_limit)
        |=> wr_addr_reg == $past(ptr_reg[2]) + {6'h00, $past(fld)})
        else $error("indexed clear address wrong");
    // Sleep restarts the watchdog and its postscaler from zero
    a_sleep_watchdog: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_sleep)
        |=> watchdog_counter == exec_pkg::watchdog_reset && postscaler_reg == 4'h0)
        else $error("watchdog not cleared on sleep");
    // Pointer 2 drops by the literal, no wrap guard by design
    a_sub_value: assert property (@(posedge clk_i) disable iff (rst_i)
        (at_q4 && is_subp && w0[7:6] == 2'd2)
        |=> ptr_reg[2] == $past(ptr_reg[2]) - {8'h00, $past(w0[5:0])})
        else $error("pointer subtract wrong");
    // A software wake leaves the expiry flag set
    a_soft_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep_reg && wake && !wd_timeout && !busy_reg)
        |=> !asleep_reg && watchdog_expiry_flag)
        else $error("software wake cleared expiry");
endmodule // exec_core
`default_nettype wire

/* File: rtl/exec_pkg.sv */
package exec_pkg;
    // Wishbone register offsets
    localparam logic [7:0] off_control    = 8'h00; // Go, ext enable, software wake
    localparam logic [7:0] off_instr      = 8'h04; // Instruction word(s)
    localparam logic [7:0] off_accum      = 8'h08; // Accumulator
    localparam logic [7:0] off_status     = 8'h0c; // Flags, busy, sleep
    localparam logic [7:0] off_pc         = 8'h10; // Program counter
    localparam logic [7:0] off_latch      = 8'h14; // Latch high and upper
    localparam logic [7:0] off_stack_head = 8'h18; // Return stack head
    localparam logic [7:0] off_bank       = 8'h1c; // Bank selector
    localparam logic [7:0] off_ptr0       = 8'h20; // Pointers 0..2 at 20h, 24h, 28h
    localparam logic [7:0] off_target     = 8'h30; // Last write address
    localparam logic [7:0] off_target_dat = 8'h34; // Last write data
    localparam logic [7:0] off_watchdog   = 8'h38; // Watchdog counter
    // Opcodes
    localparam logic [15:0] op_computed_call = 16'h0014;
    localparam logic [15:0] op_sleep         = 16'h0003;
    localparam logic [6:0]  op_clear_file    = 7'h35;    // 0110 101
    localparam logic [7:0]  op_sub_pointer   = 8'he9;    // 1110 1001
    localparam logic [3:0]  op_move_two      = 4'hc;     // 1100
    localparam logic [7:0]  idx_limit        = 8'h5f;
    localparam logic [3:0]  access_sfr_bank  = 4'hf;
    // Reset values
    localparam logic [20:0] pc_reset         = 21'h000000;
    localparam logic [7:0]  watchdog_reset   = 8'h00;
    typedef enum logic [1:0] {
        ph_q1 = 2'b00,
        ph_q2 = 2'b01,
        ph_q3 = 2'b10,
        ph_q4 = 2'b11
    } phase_t;
endpackage
